/* core/jpdp_prog_path.sv */
// programming data path: instruction register, reset chain, unlock, command and page byte registers
`timescale 1ns/1ps
module jpdp_prog_path #(
    parameter int RESET_TIMEOUT_CYCLES = 16
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    output logic             tdoOe,
    input  wire logic        testPortEnableFuse,
    input  wire logic        extReset_b,
    input  wire logic        disableWrite,
    input  wire logic        disableWriteValue,
    output logic             testPortDisableBit,
    output logic             coreReset_b,
    output logic             programmingMode,
    output logic [14:0]      flashCommand,
    output logic             flashCycle,
    input  wire logic [14:0] flashResult,
    input  wire logic [15:0] flashWord,
    output logic [7:0]       pageByte,
    output logic             pageByteHigh,
    output logic             pageWrite,
    output logic             pcStep
);
    typedef struct packed {
        logic [1:0]  extS;
        logic        portOff;
        logic [1:0]  disCnt;
        logic [3:0]  ir;
        logic [3:0]  irSh;
        logic        chain;
        logic        bypass;
        logic [15:0] sig;
        logic        prog;
        logic [14:0] cmdSh;
        logic [14:0] cmdOut;
        logic        cycle;
        logic [7:0]  hold;
        logic        loadHigh;
        logic        loadFirst;
        logic        wrPend;
        logic        readHigh;
        logic        tdo;
        logic        tdoOe;
        logic [15:0] rstCnt;
        logic        coreRst;
        logic        pageWrite;
        logic        pageHigh;
        logic        pcStep;
    } jpdp_path_reg_t;

    localparam logic [15:0] TIMEOUT_LOAD = 16'(RESET_TIMEOUT_CYCLES);

    jpdp_path_reg_t st;
    jpdp_path_reg_t next_st;
    jpdp_tap_if     tapBus ();
    logic           portOn;
    logic           rise;
    logic           capDr;
    logic           shDr;
    logic           updDr;
    logic           unlocked;

    assign portOn = testPortEnableFuse & ~st.portOff;

    jpdp_tap uTap (
        .clock  (clock),
        .rst_b  (rst_b),
        .tck    (tck),
        .tms    (tms),
        .tdi    (tdi),
        .portOn (portOn),
        .tapBus (tapBus.tap)
    );

    assign rise     = tapBus.tckRise;
    assign capDr    = rise && tapBus.state == jpdp_pkg::TAP_CAP_DR;
    assign shDr     = rise && tapBus.state == jpdp_pkg::TAP_SH_DR;
    assign updDr    = rise && tapBus.state == jpdp_pkg::TAP_UPD_DR;
    assign unlocked = st.prog;

    always_comb begin
        logic [15:0] sh;
        sh = 16'h0000;
        next_st = st;
        next_st.cycle = 1'b0;
        next_st.pageWrite = 1'b0;
        next_st.pcStep = 1'b0;
        next_st.extS = {st.extS[0], extReset_b};

        // pin reclaim: external reset held low clears the disable bit after two clocks
        if (!st.extS[1] && st.portOff) begin
            next_st.disCnt = st.disCnt + 2'h1;
            if (st.disCnt == jpdp_pkg::DISABLE_CLEAR_CLOCKS - 2'h1) begin
                next_st.portOff = 1'b0;
                next_st.disCnt = 2'h0;
            end
        end else begin
            next_st.disCnt = 2'h0;
            if (disableWrite) begin
                next_st.portOff = disableWriteValue;
            end
        end

        // instruction register path
        case (tapBus.state)
            jpdp_pkg::TAP_RESET: begin
                next_st.ir = jpdp_pkg::INS_BYPASS;
            end
            jpdp_pkg::TAP_CAP_IR: begin
                if (rise) begin
                    next_st.irSh = jpdp_pkg::IR_CAPTURE_VALUE;
                end
            end
            jpdp_pkg::TAP_SH_IR: begin
                if (rise) begin
                    sh = jpdp_pkg::shiftIn({12'h000, st.irSh}, tapBus.tdiBit, jpdp_pkg::IR_W);
                    next_st.irSh = sh[3:0];
                end
            end
            jpdp_pkg::TAP_UPD_IR: begin
                if (rise) begin
                    next_st.ir = st.irSh;
                    next_st.loadHigh = 1'b0;
                    next_st.loadFirst = 1'b1;
                    next_st.readHigh = 1'b0;
                end
            end
            default: begin
                next_st.ir = st.ir;
            end
        endcase

        // data register path
        case (st.ir)
            jpdp_pkg::INS_CORE_RESET: begin
                if (shDr) begin
                    next_st.chain = tapBus.tdiBit;
                end
            end
            jpdp_pkg::INS_UNLOCK: begin
                if (shDr) begin
                    next_st.sig = jpdp_pkg::shiftIn(st.sig, tapBus.tdiBit, jpdp_pkg::SIG_W);
                end
                if (updDr) begin
                    next_st.prog = st.sig == jpdp_pkg::UNLOCK_SIGNATURE;
                end
            end
            jpdp_pkg::INS_COMMAND: begin
                if (capDr && unlocked) begin
                    next_st.cmdSh = flashResult;
                end
                if (shDr) begin
                    sh = jpdp_pkg::shiftIn({1'b0, st.cmdSh}, tapBus.tdiBit, jpdp_pkg::CMD_W);
                    next_st.cmdSh = sh[14:0];
                end
                if (updDr && unlocked) begin
                    next_st.cmdOut = st.cmdSh;
                end
                if (rise && tapBus.state == jpdp_pkg::TAP_IDLE && unlocked) begin
                    next_st.cycle = 1'b1;
                end
            end
            jpdp_pkg::INS_PAGE_LOAD: begin
                if (shDr) begin
                    sh = jpdp_pkg::shiftIn({8'h00, st.cmdSh[7:0]}, tapBus.tdiBit, jpdp_pkg::BYTE_W);
                    next_st.cmdSh[7:0] = sh[7:0];
                end
                if (updDr && unlocked) begin
                    next_st.hold = st.cmdSh[7:0];
                    next_st.wrPend = 1'b1;
                    next_st.pageHigh = st.loadHigh;
                    next_st.loadHigh = ~st.loadHigh;
                    next_st.loadFirst = 1'b0;
                    next_st.pcStep = ~st.loadHigh & ~st.loadFirst;
                end
            end
            jpdp_pkg::INS_PAGE_READ: begin
                if (capDr && unlocked) begin
                    next_st.cmdSh[7:0] = st.readHigh ? flashWord[15:8] : flashWord[7:0];
                    next_st.readHigh = ~st.readHigh;
                    next_st.pcStep = st.readHigh;
                end
                if (shDr) begin
                    sh = jpdp_pkg::shiftIn({8'h00, st.cmdSh[7:0]}, tapBus.tdiBit, jpdp_pkg::BYTE_W);
                    next_st.cmdSh[7:0] = sh[7:0];
                end
            end
            default: begin
                if (shDr) begin
                    next_st.bypass = tapBus.tdiBit;
                end
            end
        endcase

        // the write step trails the counter step by one clock, far inside eleven TCK
        if (st.wrPend) begin
            next_st.wrPend = 1'b0;
            next_st.pageWrite = 1'b1;
        end

        // output driven on the falling TCK edge while shifting
        if (tapBus.tckFall) begin
            next_st.tdoOe = tapBus.state == jpdp_pkg::TAP_SH_DR || tapBus.state == jpdp_pkg::TAP_SH_IR;
            if (tapBus.state == jpdp_pkg::TAP_SH_IR) begin
                next_st.tdo = st.irSh[0];
            end else begin
                case (st.ir)
                    jpdp_pkg::INS_CORE_RESET: next_st.tdo = st.chain;
                    jpdp_pkg::INS_UNLOCK:     next_st.tdo = st.sig[0];
                    jpdp_pkg::INS_COMMAND:    next_st.tdo = st.cmdSh[0];
                    jpdp_pkg::INS_PAGE_LOAD:  next_st.tdo = st.cmdSh[0];
                    jpdp_pkg::INS_PAGE_READ:  next_st.tdo = st.cmdSh[0];
                    default:                  next_st.tdo = st.bypass;
                endcase
            end
        end

        // chain acts at once; release starts the time-out
        if (st.chain && !next_st.chain) begin
            next_st.rstCnt = TIMEOUT_LOAD;
        end else if (st.rstCnt != 16'h0000) begin
            next_st.rstCnt = st.rstCnt - 16'h0001;
        end
        next_st.coreRst = next_st.chain | ~st.extS[1] | (next_st.rstCnt != 16'h0000);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.extS <= 2'h3;
            st.ir <= jpdp_pkg::INS_BYPASS;
            st.sig <= jpdp_pkg::SIG_RESET;
            st.coreRst <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign tdo                = st.tdo;
    assign tdoOe              = st.tdoOe;
    assign testPortDisableBit = st.portOff;
    assign coreReset_b        = ~st.coreRst;
    assign programmingMode    = st.prog;
    assign flashCommand       = st.cmdOut;
    assign flashCycle         = st.cycle;
    assign pageByte           = st.hold;
    assign pageByteHigh       = st.pageHigh;
    assign pageWrite          = st.pageWrite;
    assign pcStep             = st.pcStep;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_load_update;
        updDr && st.ir == jpdp_pkg::INS_PAGE_LOAD && st.prog;
    endsequence
    sequence s_read_capture;
        capDr && st.ir == jpdp_pkg::INS_PAGE_READ && st.prog;
    endsequence

    property p_chain_reset;
        next_st.chain |=> !coreReset_b;
    endproperty
    a_chain_reset: assert property (p_chain_reset) else $error("chain high without core reset");
    property p_timeout;
        $fell(st.chain) |-> !coreReset_b [*2];
    endproperty
    a_timeout: assert property (p_timeout) else $error("core reset released before time-out");
    property p_bad_signature;
        updDr && st.ir == jpdp_pkg::INS_UNLOCK && st.sig != jpdp_pkg::UNLOCK_SIGNATURE |=> !programmingMode;
    endproperty
    a_bad_signature: assert property (p_bad_signature) else $error("wrong signature unlocked");
    property p_capture_result;
        capDr && st.ir == jpdp_pkg::INS_COMMAND && st.prog |=> st.cmdSh == $past(flashResult);
    endproperty
    a_capture_result: assert property (p_capture_result) else $error("command result not captured");
    property p_locked_quiet;
        !st.prog |=> !flashCycle && !pcStep;
    endproperty
    a_locked_quiet: assert property (p_locked_quiet) else $error("locked port issued a flash action");
    property p_write_follows;
        s_load_update |=> ##1 pageWrite && pageByte == $past(st.cmdSh[7:0], 2);
    endproperty
    a_write_follows: assert property (p_write_follows) else $error("page byte not written in time");
    property p_load_step;
        s_load_update |=> pcStep == ($past(!st.loadHigh) && $past(!st.loadFirst));
    endproperty
    a_load_step: assert property (p_load_step) else $error("load counter step wrong");
    property p_load_alternate;
        s_load_update |=> pageByteHigh != st.loadHigh;
    endproperty
    a_load_alternate: assert property (p_load_alternate) else $error("load byte order wrong");
    property p_read_step;
        s_read_capture |=> pcStep == $past(st.readHigh);
    endproperty
    a_read_step: assert property (p_read_step) else $error("read counter step wrong");
    property p_reclaim;
        !st.extS[1] && st.portOff && st.disCnt == 2'h0 |=> ##1 !testPortDisableBit;
    endproperty
    a_reclaim: assert property (p_reclaim) else $error("disable bit not cleared in two clocks");
endmodule

/* core/jpdp_pkg.sv */
// constants, types and shared helpers of the programming data path
// How it works
// - four-bit instruction register, sixteen codes
// - every shift register moves LSB first
// - code 0xC selects unlatched reset chain
// - reset chain never resets the TAP
// - chain high resets core, then time-out
// - code 0x4 compares signature on update
// - fixed sixteen-bit unlock signature
// - signature register clears at power-on
// - code 0x5 captures previous command result
// - update applies command, idle clocks execute
// - code 0x6 byte shares command low bits
// - update copies byte, write within eleven TCK
// - page load alternates low then high
// - counter pre-increments before low, not first
// - code 0x7 captures low then high byte
// - counter post-increments after every high read
// - usable only with fuse set, disable clear
// - external reset clears disable bit after two
package jpdp_pkg;
    localparam int         IR_W             = 4;
    localparam int         SIG_W            = 16;
    localparam int         CMD_W            = 15;
    localparam int         BYTE_W           = 8;
    localparam int         TIMEOUT_W        = 16;
    localparam logic [3:0] INS_CORE_RESET   = 4'hc;
    localparam logic [3:0] INS_UNLOCK       = 4'h4;
    localparam logic [3:0] INS_COMMAND      = 4'h5;
    localparam logic [3:0] INS_PAGE_LOAD    = 4'h6;
    localparam logic [3:0] INS_PAGE_READ    = 4'h7;
    localparam logic [3:0] INS_BYPASS       = 4'hf;
    localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
    localparam logic [15:0] UNLOCK_SIGNATURE = 16'ha370;
    localparam logic [15:0] SIG_RESET        = 16'h0000;
    localparam logic [1:0]  DISABLE_CLEAR_CLOCKS = 2'h2;
    localparam int         PAGE_WRITE_TCK   = 11;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } jpdp_tap_state_t;

    // shared by every multi-bit register: new bit enters at the top, LSB leaves first
    function automatic logic [15:0] shiftIn(input logic [15:0] value, input logic bitIn, input int width);
        logic [15:0] r;
        r = value >> 1;
        r[width-1] = bitIn;
        return r;
    endfunction
endpackage

/* core/jpdp_tap_if.sv */
// carrier between the TAP sequencer and the programming data path
`timescale 1ns/1ps
interface jpdp_tap_if;
    jpdp_pkg::jpdp_tap_state_t state;
    logic                      tckRise;
    logic                      tckFall;
    logic                      tdiBit;
    modport tap  (output state, output tckRise, output tckFall, output tdiBit);
    modport path (input state, input tckRise, input tckFall, input tdiBit);
endinterface

/* core/jpdp_tap.sv */
// TAP sequencer: pin synchronisers, TCK edge detection and the sixteen-state controller
`timescale 1ns/1ps
module jpdp_tap (
    input  wire logic  clock,
    input  wire logic  rst_b,
    input  wire logic  tck,
    input  wire logic  tms,
    input  wire logic  tdi,
    input  wire logic  portOn,
    jpdp_tap_if.tap    tapBus
);
    typedef struct packed {
        logic [2:0]                tckS;
        logic [1:0]                tmsS;
        logic [1:0]                tdiS;
        jpdp_pkg::jpdp_tap_state_t state;
    } jpdp_tap_reg_t;

    jpdp_tap_reg_t st;
    jpdp_tap_reg_t next_st;
    logic          rise;

    // only the second and third stages feed the edge detector
    assign rise = st.tckS[1] & ~st.tckS[2];

    always_comb begin
        next_st = st;
        next_st.tckS = {st.tckS[1:0], tck};
        next_st.tmsS = {st.tmsS[0], tms};
        next_st.tdiS = {st.tdiS[0], tdi};
        if (!portOn) begin
            next_st.state = jpdp_pkg::TAP_RESET;
        end else if (rise) begin
            case (st.state)
                jpdp_pkg::TAP_RESET:  next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_RESET : jpdp_pkg::TAP_IDLE;
                jpdp_pkg::TAP_IDLE:   next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_SEL_DR : jpdp_pkg::TAP_IDLE;
                jpdp_pkg::TAP_SEL_DR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_SEL_IR : jpdp_pkg::TAP_CAP_DR;
                jpdp_pkg::TAP_CAP_DR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_EX1_DR : jpdp_pkg::TAP_SH_DR;
                jpdp_pkg::TAP_SH_DR:  next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_EX1_DR : jpdp_pkg::TAP_SH_DR;
                jpdp_pkg::TAP_EX1_DR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_UPD_DR : jpdp_pkg::TAP_PA_DR;
                jpdp_pkg::TAP_PA_DR:  next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_EX2_DR : jpdp_pkg::TAP_PA_DR;
                jpdp_pkg::TAP_EX2_DR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_UPD_DR : jpdp_pkg::TAP_SH_DR;
                jpdp_pkg::TAP_UPD_DR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_SEL_DR : jpdp_pkg::TAP_IDLE;
                jpdp_pkg::TAP_SEL_IR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_RESET : jpdp_pkg::TAP_CAP_IR;
                jpdp_pkg::TAP_CAP_IR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_EX1_IR : jpdp_pkg::TAP_SH_IR;
                jpdp_pkg::TAP_SH_IR:  next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_EX1_IR : jpdp_pkg::TAP_SH_IR;
                jpdp_pkg::TAP_EX1_IR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_UPD_IR : jpdp_pkg::TAP_PA_IR;
                jpdp_pkg::TAP_PA_IR:  next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_EX2_IR : jpdp_pkg::TAP_PA_IR;
                jpdp_pkg::TAP_EX2_IR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_UPD_IR : jpdp_pkg::TAP_SH_IR;
                jpdp_pkg::TAP_UPD_IR: next_st.state = st.tmsS[1] ? jpdp_pkg::TAP_SEL_DR : jpdp_pkg::TAP_IDLE;
                default:              next_st.state = jpdp_pkg::TAP_RESET;
            endcase
        end
    end

    // only rst_b, a disabled port and TMS held high reset the controller; the core reset chain never reaches here
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{tckS: 3'h0, tmsS: 2'h3, tdiS: 2'h0, state: jpdp_pkg::TAP_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign tapBus.state   = st.state;
    assign tapBus.tckRise = rise;
    assign tapBus.tckFall = ~st.tckS[1] & st.tckS[2];
    assign tapBus.tdiBit  = st.tdiS[1];

    property p_tap_disabled;
        @(posedge clock) disable iff (!rst_b)
        !portOn |=> st.state == jpdp_pkg::TAP_RESET;
    endproperty
    a_tap_disabled: assert property (p_tap_disabled) else $error("tap left reset while port disabled");
endmodule

/* verif/jpdp_programmer_model.sv */
// programmer model: drives the test port pins and shifts every register LSB first
`timescale 1ns/1ps
module jpdp_programmer_model (
    input  wire logic clock,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // tck stands high between frames
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // 4 clocks low, 4 high: 160 ns, well below the chip clock rate
    task automatic tick(input logic tmsV, input logic tdiV, output logic tdoV);
        tck <= 1'b0;
        tms <= tmsV;
        tdi <= tdiV;
        repeat (4) @(posedge clock);
        tdoV = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    // tdi is a don't-care here, so it toggles rather than holding a stale bit
    task automatic nav(input logic tmsV);
        logic d;
        tick(tmsV, ~tdi, d);
    endtask

    task automatic navSeq(input logic [3:0] pat, input int n);
        for (int i = 0; i < n; i++) nav(pat[i]);
    endtask

    // pins used for programming only, never for scan or debug here
    task automatic toIdle();
        navSeq(4'b1111, 4);
        navSeq(4'b0001, 2);
    endtask

    task automatic loadIr(input logic [3:0] code, output logic [3:0] cap);
        navSeq(4'b0011, 4);
        for (int i = 0; i < 4; i++) tick(i == 3, code[i], cap[i]);
        navSeq(4'b0001, 2);
    endtask

    task automatic scanDr(input int w, input logic [15:0] d, output logic [15:0] q);
        q = '0;
        navSeq(4'b0001, 3);
        for (int i = 0; i < w; i++) tick(i == w - 1, d[i], q[i]);
        navSeq(4'b0001, 2);
        // the write pulse trails the update by two clocks; let it land before anyone looks
        repeat (2) @(posedge clock);
    endtask
endmodule

/* verif/jtag_programming_data_path_tb.sv */
// self-checking bench of the programming data path
`timescale 1ns/1ps
module jtag_programming_data_path_tb;
    logic        clock, rst_b, tck, tms, tdi, tdo, tdoOe, testPortEnableFuse, extReset_b;
    logic        disableWrite, disableWriteValue, testPortDisableBit, coreReset_b, programmingMode;
    logic        flashCycle, pageByteHigh, pageWrite, pcStep;
    logic [14:0] flashCommand, flashResult, lastCmd;
    logic [15:0] flashWord;
    logic [7:0]  pageByte;
    logic [15:0] mem [4];
    logic [15:0] badSig [3] = '{16'ha371, 16'h0ec5, 16'h2370};
    logic [8:0]  wrQ [$];
    int          seed = 32'h805e;
    int          errorCnt = 0, checksDone = 0, cycCnt = 0, oeCnt = 0, pcCount = 0;

    jpdp_prog_path #(.RESET_TIMEOUT_CYCLES(16)) i_dut (
        .clock(clock), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
        .testPortEnableFuse(testPortEnableFuse), .extReset_b(extReset_b), .disableWrite(disableWrite),
        .disableWriteValue(disableWriteValue), .testPortDisableBit(testPortDisableBit),
        .coreReset_b(coreReset_b), .programmingMode(programmingMode), .flashCommand(flashCommand),
        .flashCycle(flashCycle), .flashResult(flashResult), .flashWord(flashWord), .pageByte(pageByte),
        .pageByteHigh(pageByteHigh), .pageWrite(pageWrite), .pcStep(pcStep)
    );
    jpdp_programmer_model i_prog (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // word at the program counter; a stepping slip shows as a wrong byte
    assign flashWord = mem[pcCount[1:0]];

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        if (pageWrite === 1'b1) wrQ.push_back({pageByteHigh, pageByte});
        if (pcStep === 1'b1) pcCount <= pcCount + 1;
        if (flashCycle === 1'b1) cycCnt <= cycCnt + 1;
        if (tdoOe === 1'b1) oeCnt <= oeCnt + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic completeRun();
        $display("comparisons %0d, mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clock);
        errorCnt++;
        $display("unexpected at %0t: run hung", $time);
        completeRun();
    end

    initial begin
        logic [3:0]  cap;
        logic [15:0] q, cmd, want;
        logic        b;
        int          base, n;
        rst_b = 1'b0;
        extReset_b = 1'b1;
        testPortEnableFuse = 1'b1;
        disableWrite = 1'b0;
        disableWriteValue = 1'b0;
        flashResult = '0;
        for (int i = 0; i < 4; i++) mem[i] = $random(seed);
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        check(coreReset_b, 1'b1);
        check(programmingMode, 1'b0);
        i_prog.toIdle();
        i_prog.loadIr(4'h5, cap);
        check(cap, 4'h1);
        cmd = $random(seed);
        n = oeCnt;
        i_prog.scanDr(15, cmd, q);
        check(flashCommand, 15'h0);
        check(oeCnt - n, 15 * 8);
        n = cycCnt;
        i_prog.navSeq(4'b0000, 3);
        @(posedge clock);
        check(cycCnt - n, 0);
        // core goes into reset before any unlock attempt
        i_prog.loadIr(4'hc, cap);
        i_prog.scanDr(1, 16'h1, q);
        check(coreReset_b, 1'b0);
        i_prog.loadIr(4'h4, cap);
        check(cap, 4'h1);
        foreach (badSig[i]) begin
            i_prog.scanDr(16, badSig[i], q);
            check(programmingMode, 1'b0);
        end
        i_prog.scanDr(16, 16'ha370, q);
        check(programmingMode, 1'b1);
        // release the chain by hand to time the reset tail
        i_prog.loadIr(4'hc, cap);
        i_prog.navSeq(4'b0001, 3);
        i_prog.tick(1'b1, 1'b0, b);
        check(coreReset_b, 1'b0);
        repeat (8) @(posedge clock);
        check(coreReset_b, 1'b0);
        repeat (16) @(posedge clock);
        check(coreReset_b, 1'b1);
        i_prog.navSeq(4'b0001, 2);
        i_prog.loadIr(4'h5, cap);
        for (int i = 0; i < 3; i++) begin
            want = $random(seed);
            flashResult <= want[14:0];
            cmd = $random(seed);
            lastCmd = cmd[14:0];
            i_prog.scanDr(15, cmd, q);
            check(q[14:0], want[14:0]);
            check(flashCommand, cmd[14:0]);
            n = cycCnt;
            i_prog.navSeq(4'b0000, i + 1);
            // the last idle pulse is counted on the edge the task returns on
            @(posedge clock);
            check(cycCnt - n, i + 1);
        end
        for (int r = 0; r < 2; r++) begin
            i_prog.loadIr(4'h6, cap);
            base = pcCount;
            for (int k = 0; k < 3; k++) begin
                cmd = $random(seed);
                i_prog.scanDr(8, cmd, q);
                check(wrQ.size(), 1);
                if (wrQ.size() > 0) check(wrQ.pop_front(), {k[0], cmd[7:0]});
            end
            check(pcCount - base, 1);
        end
        i_prog.loadIr(4'h7, cap);
        base = pcCount;
        for (int k = 0; k < 5; k++) begin
            want = mem[(base + k / 2) % 4];
            cmd = $random(seed);
            i_prog.scanDr(8, cmd, q);
            check(q[7:0], k[0] ? want[15:8] : want[7:0]);
        end
        check(pcCount - base, 2);
        // leaving programming mode: signature cleared, commands ignored again
        i_prog.loadIr(4'h4, cap);
        i_prog.scanDr(16, 16'h0, q);
        check(programmingMode, 1'b0);
        i_prog.loadIr(4'h5, cap);
        cmd = $random(seed);
        i_prog.scanDr(15, cmd, q);
        check(flashCommand, lastCmd);
        testPortEnableFuse <= 1'b0;
        n = oeCnt;
        i_prog.loadIr(4'h5, cap);
        check(oeCnt - n, 0);
        testPortEnableFuse <= 1'b1;
        disableWriteValue <= 1'b1;
        disableWrite <= 1'b1;
        @(posedge clock);
        disableWrite <= 1'b0;
        repeat (2) @(posedge clock);
        check(testPortDisableBit, 1'b1);
        n = oeCnt;
        i_prog.toIdle();
        i_prog.loadIr(4'h5, cap);
        check(oeCnt - n, 0);
        extReset_b <= 1'b0;
        n = 0;
        while (testPortDisableBit !== 1'b0 && n < 12) begin
            @(posedge clock);
            n++;
        end
        check(n >= 4 && n <= 7, 1'b1);
        check(coreReset_b, 1'b0);
        extReset_b <= 1'b1;
        repeat (4) @(posedge clock);
        i_prog.toIdle();
        i_prog.loadIr(4'h5, cap);
        check(cap, 4'h1);
        completeRun();
    end
endmodule
